/* fsr_consts.svh */
// fsr_consts.svh: offsets, field positions, timing counts of the host
// assumes: included by the package and by the controller module
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FSR_CLK_NS       50
// least strobe low time on the flash bus
`define FSR_T_STROBE_NS  100
// chip_select_high_time / output_enable_high_time, least
`define FSR_T_GAP_NS     60
`define FSR_STROBE_CYC   ((`FSR_T_STROBE_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_GAP_CYC      ((`FSR_T_GAP_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)

// ----------------------------------------------------------------
// apb register offsets
// ----------------------------------------------------------------
`define FSR_OFS_CTRL     8'h00
`define FSR_OFS_ADDR     8'h04
`define FSR_OFS_WDATA    8'h08
`define FSR_OFS_STATUS   8'h0C
`define FSR_OFS_RDATA    8'h10

// ----------------------------------------------------------------
// operation codes written to ctrl[2:0]
// ----------------------------------------------------------------
`define FSR_OP_WRITE     3'h0
`define FSR_OP_READ      3'h1
`define FSR_OP_SR_READ   3'h2
`define FSR_OP_CLEAR     3'h3
`define FSR_OP_WAIT      3'h4
`define FSR_OP_TOGGLE    3'h5
`define FSR_OP_LAST      3'h5

// ----------------------------------------------------------------
// operation_status_word and polling word bits
// ----------------------------------------------------------------
`define FSR_SR_READY     7
`define FSR_SR_ERS_SUSP  6
`define FSR_SR_ERS_FAIL  5
`define FSR_SR_PRG_FAIL  4
`define FSR_SR_ABORT     3
`define FSR_SR_PRG_SUSP  2
`define FSR_SR_LOCKED    1
`define FSR_TOGGLE_BIT   6

// ----------------------------------------------------------------
// status register of the controller
// ----------------------------------------------------------------
`define FSR_ST_BUSY      0
`define FSR_ST_READY     1
`define FSR_ST_FLAGS_LO  2
`define FSR_ST_STOPPED   8

`endif

/* fsr_pkg.sv */
// fsr_pkg.sv: types shared by the status-reporting host controller
// assumes: fsr_consts.svh on the include path
package fsr_pkg;
  `include "fsr_consts.svh"

  typedef enum logic [1:0] {
    FSR_IDLE,
    FSR_SETUP,
    FSR_STROBE,
    FSR_GAP
  } fsr_state_e;

  // pins driven toward the flash bus
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] dq;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } fsr_pins_s;
endpackage : fsr_pkg

/* fsr_host.sv */
// fsr_host.sv: apb-driven host that issues flash bus cycles and reads
// the operation_status_word and the polling word of a parallel flash
// assumes: flash dq inputs synchronous to pclk, one 20 MHz clock
`timescale 1ns/1ps
`include "fsr_consts.svh"

module fsr_host
  import fsr_pkg::*;
#(
  parameter logic [15:0] SR_CMD  = 16'h0070,
  parameter logic [15:0] CLR_CMD = 16'h0071
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output fsr_pins_s        pins,
  input  wire logic [15:0] flash_dq_i
);

  localparam logic [3:0] STROBE_CYC = 4'(`FSR_STROBE_CYC);
  localparam logic [3:0] GAP_CYC    = 4'(`FSR_GAP_CYC);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fsr_state_e  state_reg,   state_next;
  logic [2:0]  op_reg,      op_next;
  logic        step_reg,    step_next;
  logic [3:0]  cnt_reg,     cnt_next;
  logic [23:0] addr_reg,    addr_next;
  logic [15:0] wdata_reg,   wdata_next;
  logic [15:0] rdata_reg,   rdata_next;
  logic [15:0] prev_reg,    prev_next;
  logic        ready_reg,   ready_next;
  logic [5:0]  flags_reg,   flags_next;
  logic        stopped_reg, stopped_next;
  fsr_pins_s   pins_reg,    pins_next;

  logic        acc;
  logic        wr_acc;
  logic        start;
  logic        fin;
  logic        is_wr;
  logic        sr_op;
  logic [15:0] cyc_data;

  assign acc    = psel && penable;
  assign wr_acc = acc && pwrite;
  assign start  = wr_acc && (paddr == `FSR_OFS_CTRL)
                  && (state_reg == FSR_IDLE)
                  && (pwdata[2:0] <= `FSR_OP_LAST);
  assign pready = 1'b1;
  assign pins   = pins_reg;

  // ----------------------------------------------------------------
  // apb read side
  // ----------------------------------------------------------------
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      `FSR_OFS_CTRL:   prdata = {29'h0000_0000, op_reg};
      `FSR_OFS_ADDR:   prdata = {8'h00, addr_reg};
      `FSR_OFS_WDATA:  prdata = {16'h0000, wdata_reg};
      `FSR_OFS_STATUS: begin
        prdata[`FSR_ST_BUSY]    = (state_reg != FSR_IDLE);
        prdata[`FSR_ST_READY]   = ready_reg;
        prdata[`FSR_ST_FLAGS_LO +: 6] = flags_reg;
        prdata[`FSR_ST_STOPPED] = stopped_reg;
      end
      `FSR_OFS_RDATA:  prdata = {16'h0000, rdata_reg};
      default:         pslverr = acc;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    op_next      = op_reg;
    step_next    = step_reg;
    cnt_next     = cnt_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    rdata_next   = rdata_reg;
    prev_next    = prev_reg;
    ready_next   = ready_reg;
    flags_next   = flags_reg;
    stopped_next = stopped_reg;
    fin          = 1'b0;

    if (wr_acc && paddr == `FSR_OFS_ADDR)
      addr_next = pwdata[23:0];
    if (wr_acc && paddr == `FSR_OFS_WDATA)
      wdata_next = pwdata[15:0];

    unique case (state_reg)
      FSR_IDLE: begin
        if (start) begin
          op_next      = pwdata[2:0];
          step_next    = 1'b0;
          stopped_next = 1'b0;
          state_next   = FSR_SETUP;
        end
      end
      FSR_SETUP: begin
        cnt_next   = STROBE_CYC - 4'd1;
        state_next = FSR_STROBE;
      end
      FSR_STROBE: begin
        if (cnt_reg != 4'd0) begin
          cnt_next = cnt_reg - 4'd1;
        end else begin
          if (!pins_reg.oe_n) begin
            prev_next = rdata_reg;
            if ((op_reg == `FSR_OP_SR_READ)
                || (op_reg == `FSR_OP_WAIT)) begin
              rdata_next = {8'h00, flash_dq_i[7:0]};
              ready_next = flash_dq_i[`FSR_SR_READY];
              flags_next = flash_dq_i[`FSR_SR_READY]
                           ? flash_dq_i[`FSR_SR_ERS_SUSP:`FSR_SR_LOCKED]
                           : 6'h00;
            end else begin
              rdata_next = flash_dq_i;
            end
          end
          cnt_next   = GAP_CYC - 4'd1;
          state_next = FSR_GAP;
        end
      end
      FSR_GAP: begin
        if (cnt_reg != 4'd0) begin
          cnt_next = cnt_reg - 4'd1;
        end else begin
          state_next = FSR_SETUP;
          unique case (op_reg)
            `FSR_OP_SR_READ: begin
              if (step_reg) fin = 1'b1;
              step_next = 1'b1;
            end
            `FSR_OP_WAIT: begin
              if (step_reg && ready_reg) fin = 1'b1;
              step_next = !step_reg;
            end
            `FSR_OP_TOGGLE: begin
              if (step_reg && rdata_reg[`FSR_TOGGLE_BIT]
                  == prev_reg[`FSR_TOGGLE_BIT]) begin
                fin          = 1'b1;
                stopped_next = 1'b1;
              end
              step_next = 1'b1;
            end
            default: fin = 1'b1;
          endcase
          if (fin) state_next = FSR_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // pin drive, computed from next state so pins come from flops
  // ----------------------------------------------------------------
  always_comb begin
    sr_op = (op_next == `FSR_OP_SR_READ) || (op_next == `FSR_OP_WAIT);
    // first cycle writes the status command
    is_wr = (op_next == `FSR_OP_WRITE) || (op_next == `FSR_OP_CLEAR)
            || (sr_op && !step_next);
    if (op_next == `FSR_OP_WRITE)
      cyc_data = wdata_next;
    else if (op_next == `FSR_OP_CLEAR)
      cyc_data = CLR_CMD;
    else
      cyc_data = SR_CMD;
    pins_next.addr  = addr_next;
    pins_next.dq    = cyc_data;
    // dq released before the flash may drive it
    pins_next.dq_oe = is_wr && (state_next != FSR_IDLE)
                      && (state_next != FSR_GAP);
    pins_next.ce_n  = (state_next == FSR_IDLE) || (state_next == FSR_GAP);
    pins_next.we_n  = !(is_wr && state_next == FSR_STROBE);
    pins_next.oe_n  = !(!is_wr && state_next == FSR_STROBE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= FSR_IDLE;
      op_reg      <= `FSR_OP_WRITE;
      step_reg    <= 1'b0;
      cnt_reg     <= 4'd0;
      addr_reg    <= 24'h00_0000;
      wdata_reg   <= 16'h0000;
      rdata_reg   <= 16'h0000;
      prev_reg    <= 16'h0000;
      // flash reset state: ready, flags clear
      ready_reg   <= 1'b1;
      flags_reg   <= 6'h00;
      stopped_reg <= 1'b0;
      pins_reg    <= '{addr: 24'h00_0000, dq: 16'h0000, dq_oe: 1'b0,
                       ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else begin
      state_reg   <= state_next;
      op_reg      <= op_next;
      step_reg    <= step_next;
      cnt_reg     <= cnt_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      rdata_reg   <= rdata_next;
      prev_reg    <= prev_next;
      ready_reg   <= ready_next;
      flags_reg   <= flags_next;
      stopped_reg <= stopped_next;
      pins_reg    <= pins_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_no_contend;
    !pins.oe_n |-> !pins.dq_oe && !pins.ce_n;
  endproperty
  a_no_contend: assert property (p_no_contend)
    else $error("host drives dq during a read");

  property p_one_strobe;
    !(!pins.oe_n && !pins.we_n);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("write and read strobes low together");

  property p_high_time;
    $rose(pins.oe_n) |-> (pins.ce_n && pins.oe_n)[*2];
  endproperty
  a_high_time: assert property (p_high_time)
    else $error("strobes not held high after read");

  property p_strobe_width;
    $fell(pins.we_n) |-> (!pins.we_n)[*2];
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("write strobe too short");

  property p_sr_seq;
    start && pwdata[2:0] == `FSR_OP_SR_READ
      |-> ##[1:4] !pins.we_n ##[1:12] !pins.oe_n;
  endproperty
  a_sr_seq: assert property (p_sr_seq)
    else $error("status read missing command or read");

  property p_upper_zero;
    fin && op_reg == `FSR_OP_SR_READ |=> rdata_reg[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper status byte kept");

  property p_busy_flags;
    !ready_reg |-> flags_reg == 6'h00;
  endproperty
  a_busy_flags: assert property (p_busy_flags)
    else $error("flags kept while flash busy");

  property p_wait_ready;
    fin && op_reg == `FSR_OP_WAIT |-> ready_reg;
  endproperty
  a_wait_ready: assert property (p_wait_ready)
    else $error("wait ended while flash busy");

  property p_toggle_end;
    fin && op_reg == `FSR_OP_TOGGLE
      |-> rdata_reg[6] == prev_reg[6] ##1 stopped_reg;
  endproperty
  a_toggle_end: assert property (p_toggle_end)
    else $error("toggle poll ended while bit 6 toggles");

endmodule : fsr_host

/* fsr_flash_model.sv */
// fsr_flash_model.sv: behavioural flash status side for the bench
// assumes: strobes from fsr_host; busy and flags are set by the bench
`timescale 1ns/1ps

module fsr_flash_model
  import fsr_pkg::*;
#(
  parameter logic [15:0] SR_CMD  = 16'h0070,
  parameter logic [15:0] CLR_CMD = 16'h0071
) (
  input  wire fsr_pins_s   pins,
  input  wire logic        busy,
  input  wire logic        load,
  input  wire logic [6:1]  load_flags,
  output logic      [15:0] dq_o
);
  logic [6:1]  sr_reg = '0;
  logic        ovl    = 1'b0;
  logic        tog    = 1'b0;
  logic [15:0] mem    = 16'h1234;
  logic [15:0] last   = '0;
  logic [15:0] word;

  always @(posedge load) sr_reg = load_flags;

  always @(posedge pins.we_n) begin
    if (pins.dq == SR_CMD) ovl = 1'b1;
    else if (pins.dq == CLR_CMD) sr_reg = sr_reg & 6'h22;
    else if (!$isunknown(pins.dq)) mem = pins.dq;
  end

  // bench holds busy for the poll window, then array
  // upper byte is junk so a host that keeps it is caught
  always @* begin
    if (busy) word = {8'h5A, ~mem[7], tog, 6'h00};
    else if (ovl) word = {8'hA5, 1'b1, sr_reg, 1'b0};
    else word = mem;
  end

  always @(posedge pins.oe_n) begin
    last = word;
    ovl  = 1'b0;
    if (busy) tog = ~tog;
  end

  // released lines show inverse of last word
  assign dq_o = (!pins.ce_n && !pins.oe_n) ? word : ~last;
endmodule : fsr_flash_model

/* fsr_host_bench.sv */
// fsr_host_bench.sv: self-checking bench for fsr_host
// assumes: fsr_pkg compiled, flash model on the far side
`timescale 1ns/1ps

module fsr_host_bench;
  import fsr_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = '0;
  logic [31:0] pwdata  = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  fsr_pins_s   pins;
  logic [15:0] fdq;
  logic        busy    = 1'b0;
  logic        load    = 1'b0;
  logic [6:1]  lflags  = '0;
  logic [31:0] q;
  logic        e;
  logic        t6;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  // flags beside the expected low status byte
  logic [13:0] rows [7] = '{14'h0002, 14'h0106, 14'h020A, 14'h0412,
                            14'h0822, 14'h1042, 14'h2082};

  always #25 pclk = ~pclk;

  fsr_host uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .flash_dq_i(fdq));

  fsr_flash_model flash (.pins(pins), .busy(busy), .load(load),
    .load_flags(lflags), .dq_o(fdq));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("TB: comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, '0);
  endtask : rd

  task automatic go(input logic [2:0] o);
    apb(1'b1, 8'h00, {29'h0, o});
  endtask : go

  // polls STATUS, leaves its last value in q
  task automatic fin;
    int n;
    n = 0;
    do begin
      rd(8'h0C);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    // a poll limit that runs out is a mismatch
    if (q[0] !== 1'b0) begin
      fail_count++;
      close_out();
    end
  endtask : fin

  task automatic run(input logic [2:0] o);
    go(o);
    fin();
  endtask : run

  task automatic setf(input logic [6:1] f);
    @(posedge pclk);
    lflags <= f;
    load   <= 1'b1;
    @(posedge pclk);
    load   <= 1'b0;
  endtask : setf

  // ----------------------------------------------------------------
  // timeout
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      setf(rows[i][13:8]);
      run(3'h2);
      chk("status", {24'h0, q[7:0]}, {24'h0, rows[i][7:0]});
      rd(8'h10);
      chk("rdata", q, {24'h0, 1'b1, rows[i][13:8], 1'b0});
    end
    setf(6'h3F);
    run(3'h3);
    run(3'h2);
    chk("cleared", {24'h0, q[7:0]}, 32'h0000_008A);
    rd(8'h20);
    chk("slverr", {31'h0, e}, 32'h0000_0001);
    chk("unmapped", q, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h00AB_CDEF);
    rd(8'h04);
    chk("addr", q, 32'h00AB_CDEF);
    apb(1'b1, 8'h08, 32'h0000_0080);
    run(3'h0);
    busy <= 1'b1;
    run(3'h1);
    rd(8'h10);
    chk("poll7", {31'h0, q[7]}, 32'h0000_0000);
    t6 = q[6];
    run(3'h1);
    rd(8'h10);
    chk("toggle", {31'h0, q[6]}, {31'h0, ~t6});
    run(3'h2);
    chk("busy st", {24'h0, q[7:0]}, 32'h0000_0000);
    go(3'h5);
    repeat (40) @(posedge pclk);
    rd(8'h0C);
    chk("polling", {31'h0, q[0]}, 32'h0000_0001);
    // a start while busy must be ignored
    go(3'h1);
    rd(8'h00);
    chk("busy ctrl", q, 32'h0000_0005);
    busy <= 1'b0;
    fin();
    chk("stopped", {31'h0, q[8]}, 32'h0000_0001);
    busy <= 1'b1;
    go(3'h4);
    repeat (40) @(posedge pclk);
    rd(8'h0C);
    chk("waiting", {31'h0, q[0]}, 32'h0000_0001);
    busy <= 1'b0;
    fin();
    rd(8'h10);
    chk("ready", {31'h0, q[7]}, 32'h0000_0001);
    run(3'h1);
    rd(8'h10);
    chk("array", q, 32'h0000_0080);
    chk("pin addr", {8'h0, pins.addr}, 32'h00AB_CDEF);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h0C);
    chk("rst st", q, 32'h0000_0002);
    rd(8'h10);
    chk("rst rd", q, 32'h0000_0000);
    // op code above the last one must not start a cycle
    go(3'h6);
    rd(8'h0C);
    chk("bad op", q, 32'h0000_0002);
    close_out();
  end
endmodule : fsr_host_bench
